// ===== src/qct_unit.sv
// Functional notes
// - four independent 16-bit counter channels
// - separate converter pacing clock from same circuitry
// - cascade routes clock output to next counter
// - cascade only for pairs 0-1, 1-2, 2-3
// - lower counter clock and gate govern pair
// - internal 20 MHz base, act on rising edge
// - internal output up to 10 MHz, wide range
// - external output is clock over divider 2..65535
// - only rising edge of external or cascade clock
// - enabled operation starts on next clock edge
// - gate none enables on software command
// - low level gate runs low, pauses high
// - high level gate runs high, pauses low
// - falling gate edge triggers one-shot modes
// - rising gate edge triggers one-shot modes
// - per-counter clock, gate and pulse pins
// - selectable output polarity defines active portion
// - duty percentage sets active fraction of period
// - event count wraps at 2^16, pair 2^32
// - rate output runs only while gate enables
// - one-shot emits single pulse then ignores inputs
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module qct_unit
  import qct_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output var  logic [31:0] RD_DATA,
  input  wire logic [3:0]  EXT_CLK,
  input  wire logic [3:0]  EXT_GATE,
  output var  logic [3:0]  PULSE_OUT,
  output var  logic        ADC_TICK
);

  qct_regs_t   s;
  qct_regs_t   next_s;

  // per-channel derived terms, filled by the generate loop
  logic [3:0]  tick_v;
  logic [3:0]  en_v;
  logic [3:0]  run_ok_v;
  logic [3:0]  trig_v;
  logic [3:0]  shot_v;
  logic [3:0]  count_v;
  logic [15:0] div_v [4];
  logic [15:0] act_v [4];

  // clock source, governing gate and period shape of each channel
  for (genvar i = 0; i < NUM_CH; i++) begin : gen_ch
    logic        casc;
    logic        ext_rise;
    // two bits reach every channel; a pair never points past three
    logic [1:0]  g;
    logic        gl;
    logic        gp;
    qct_gate_t   gt;
    logic [22:0] prod;

    if (i == 0) begin : gen_first
      assign casc = 1'b0;
    end else begin : gen_rest
      assign casc = s.cascade[i-1];
    end

    // edge detect on the pin; pins are already in the clock domain
    assign ext_rise = EXT_CLK[i] & ~s.chan[i].clk_prev;

    // cascaded upper counter clocks from the lower's clock output
    assign tick_v[i] = casc ? s.chan[i-1 < 0 ? 0 : i-1].carry
                     : (s.chan[i].ext ? ext_rise
                                      : s.tb_tick);

    // lower counter of a pair owns gate and enable
    assign g  = casc ? 2'(i - 1) : 2'(i);
    assign gl = EXT_GATE[g];
    assign gp = s.chan[g].gate_prev;
    assign gt = s.chan[g].gate;
    assign en_v[i] = s.chan[g].en;

    always_comb begin : gate_decode
      run_ok_v[i] = 1'b0;
      trig_v[i]   = 1'b0;
      unique case (gt)
        QCT_GATE_NONE: begin
          run_ok_v[i] = 1'b1;
          trig_v[i]   = 1'b1;
        end
        QCT_GATE_LOW:  run_ok_v[i] = ~gl;
        QCT_GATE_HIGH: run_ok_v[i] = gl;
        QCT_GATE_FALL: begin
          run_ok_v[i] = 1'b1;
          trig_v[i]   = gp & ~gl;
        end
        QCT_GATE_RISE: begin
          run_ok_v[i] = 1'b1;
          trig_v[i]   = ~gp & gl;
        end
        default: begin
          run_ok_v[i] = 1'b0;
          trig_v[i]   = 1'b0;
        end
      endcase
    end

    assign shot_v[i]  = (s.chan[i].mode == QCT_MODE_SHOT) ||
                        (s.chan[i].mode == QCT_MODE_REPEAT);
    assign count_v[i] = (s.chan[i].mode == QCT_MODE_EVENT) ||
                        (s.chan[i].mode == QCT_MODE_FREQ);

    // software loads base/frequency; below two is raised to two
    assign div_v[i] = (s.chan[i].div < DIV_MIN) ? DIV_MIN
                                                : s.chan[i].div;
    // rounded product; duty is capped at full so it fits the divider
    assign prod     = 23'(div_v[i] * s.chan[i].duty)
                    + 23'(DUTY_HALF);
    assign act_v[i] = 16'(prod / 23'(DUTY_FULL));
  end

  // all next-state logic for time base, pacing clock, channels and bus
  always_comb begin : next_state_logic
    next_s = s;

    // 20 MHz time base as a one-cycle enable every five clocks
    next_s.tb_tick = 1'b0;
    if (s.tb_cnt == TB_CYCLES - 3'd1) begin
      next_s.tb_cnt  = 3'h0;
      next_s.tb_tick = 1'b1;
    end else begin
      next_s.tb_cnt = s.tb_cnt + 3'd1;
    end

    // converter pacing divider, never shared with user channels
    next_s.adc_tick = 1'b0;
    if (s.tb_tick) begin
      if (s.adc_cnt >= s.adc_div - 16'd1 || s.adc_div < DIV_MIN) begin
        next_s.adc_cnt  = 16'h0;
        next_s.adc_tick = 1'b1;
      end else begin
        next_s.adc_cnt = s.adc_cnt + 16'd1;
      end
    end

    for (int c = 0; c < NUM_CH; c++) begin
      next_s.chan[c].clk_prev  = EXT_CLK[c];
      next_s.chan[c].gate_prev = EXT_GATE[c];
      next_s.chan[c].carry     = 1'b0;

      unique case (s.chan[c].st)
        QCT_ST_IDLE: begin
          if (en_v[c]) begin
            next_s.chan[c].phase = 16'h0;
            next_s.chan[c].st    = shot_v[c] ? QCT_ST_ARMED
                                             : QCT_ST_RUN;
          end
        end
        QCT_ST_ARMED: begin
          if (!en_v[c]) begin
            next_s.chan[c].st = QCT_ST_IDLE;
          end else if (trig_v[c]) begin
            // the trigger only starts the run at phase zero; clock edges do the work
            next_s.chan[c].phase = 16'h0;
            next_s.chan[c].st    = QCT_ST_RUN;
          end
        end
        QCT_ST_RUN: begin
          if (!en_v[c]) begin
            next_s.chan[c].st = QCT_ST_IDLE;
          end else if (tick_v[c] && run_ok_v[c]) begin
            if (count_v[c]) begin
              // 16-bit add wraps by itself; the carry feeds the pair
              next_s.chan[c].cnt   = s.chan[c].cnt + 16'd1;
              next_s.chan[c].carry = (s.chan[c].cnt == 16'hFFFF);
            end else if (s.chan[c].phase >= div_v[c]) begin
              // the edge that closes a period also opens the next one
              next_s.chan[c].phase = 16'h1;
              next_s.chan[c].carry = 1'b1;
              if (s.chan[c].mode == QCT_MODE_SHOT) begin
                next_s.chan[c].st = QCT_ST_DONE;
              end else if (s.chan[c].mode == QCT_MODE_REPEAT) begin
                next_s.chan[c].st = QCT_ST_ARMED;
              end
            end else begin
              next_s.chan[c].phase = s.chan[c].phase + 16'd1;
            end
          end else if (!run_ok_v[c] && !count_v[c]) begin
            // rate output halts at once and restarts a full period
            next_s.chan[c].phase = 16'h0;
          end
        end
        QCT_ST_DONE: begin
          // everything but a software disable is ignored here
          if (!en_v[c]) begin
            next_s.chan[c].st = QCT_ST_IDLE;
          end
        end
      endcase

      // pulse pin: active for the first act_v ticks of each period;
      // phase zero waits for the first clock edge, so no early pulse
      next_s.chan[c].out = ((next_s.chan[c].st == QCT_ST_RUN) &&
                            !count_v[c] && run_ok_v[c] &&
                            (next_s.chan[c].phase != 16'h0) &&
                            (next_s.chan[c].phase <= act_v[c]))
                           ^ s.chan[c].pol_hl;
    end

    // register writes take effect after the channel update
    if (WR_EN) begin
      if (ADDR[7:6] == 2'b00) begin
        unique case (ADDR[3:0])
          REG_CTRL: begin
            next_s.chan[ADDR[5:4]].mode   =
              qct_mode_t'(WR_DATA[CTRL_MODE_LSB +: 3]);
            next_s.chan[ADDR[5:4]].gate   =
              qct_gate_t'(WR_DATA[CTRL_GATE_LSB +: 3]);
            next_s.chan[ADDR[5:4]].ext    = WR_DATA[CTRL_EXT_BIT];
            next_s.chan[ADDR[5:4]].pol_hl = WR_DATA[CTRL_POL_BIT];
            next_s.chan[ADDR[5:4]].en     = WR_DATA[CTRL_EN_BIT];
            // a control write restarts the channel from a clean count
            next_s.chan[ADDR[5:4]].st     = QCT_ST_IDLE;
            next_s.chan[ADDR[5:4]].cnt    = 16'h0;
            next_s.chan[ADDR[5:4]].phase  = 16'h0;
          end
          REG_DIV:  next_s.chan[ADDR[5:4]].div = WR_DATA[15:0];
          REG_DUTY: begin
            next_s.chan[ADDR[5:4]].duty =
              (WR_DATA[31:0] > 32'(DUTY_FULL)) ? DUTY_FULL
                                               : WR_DATA[6:0];
          end
          default: ;
        endcase
      end else if (ADDR == REG_CASCADE) begin
        next_s.cascade = WR_DATA[2:0];
      end else if (ADDR == REG_ADC_DIV) begin
        next_s.adc_div = WR_DATA[15:0];
      end
    end

    // read data stands for exactly one cycle, zero otherwise
    next_s.rd_data = 32'h0;
    if (RD_EN) begin
      if (ADDR[7:6] == 2'b00) begin
        unique case (ADDR[3:0])
          REG_CTRL: next_s.rd_data = {23'h0, s.chan[ADDR[5:4]].en,
                                      s.chan[ADDR[5:4]].pol_hl,
                                      s.chan[ADDR[5:4]].ext,
                                      s.chan[ADDR[5:4]].gate,
                                      s.chan[ADDR[5:4]].mode};
          REG_DIV:   next_s.rd_data = {16'h0, s.chan[ADDR[5:4]].div};
          REG_DUTY:  next_s.rd_data = {25'h0, s.chan[ADDR[5:4]].duty};
          REG_COUNT: next_s.rd_data = {16'h0, s.chan[ADDR[5:4]].cnt};
          default:   next_s.rd_data = 32'h0;
        endcase
      end else if (ADDR == REG_CASCADE) begin
        next_s.rd_data = {29'h0, s.cascade};
      end else if (ADDR == REG_ADC_DIV) begin
        next_s.rd_data = {16'h0, s.adc_div};
      end else if (ADDR == REG_STATUS) begin
        next_s.rd_data = {24'h0, s.chan[3].st, s.chan[2].st,
                          s.chan[1].st, s.chan[0].st};
      end
    end
  end

  // the one state register; pulse pins reset low, idle for polarity 0
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        s.chan[c].div  <= DIV_RST;
        s.chan[c].duty <= DUTY_HALF;
      end
      s.adc_div <= ADC_DIV_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign RD_DATA  = s.rd_data;
  assign ADC_TICK = s.adc_tick;
  for (genvar j = 0; j < NUM_CH; j++) begin : gen_pin
    assign PULSE_OUT[j] = s.chan[j].out;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // named steps shared by the idle and one-shot checks
  sequence s_idle_two;
    (s.chan[0].st == QCT_ST_IDLE) [*2];
  endsequence

  sequence s_shot_end;
    s.chan[2].st == QCT_ST_RUN && s.chan[2].mode == QCT_MODE_SHOT &&
    tick_v[2] && run_ok_v[2] && en_v[2] && !WR_EN &&
    s.chan[2].phase >= div_v[2];
  endsequence

  a_time_base_rate: assert property (
    s.tb_tick |=> !s.tb_tick [*4] ##1 s.tb_tick)
    else $error("time base tick spacing wrong");

  a_read_one_cycle: assert property (
    RD_EN && ADDR == (CH_STRIDE + 8'(REG_COUNT)) |=>
      RD_DATA == {16'h0, $past(s.chan[1].cnt)} ##1
      (RD_DATA == 32'h0 || $past(RD_EN)))
    else $error("count read data wrong or held");

  a_event_wrap: assert property (
    s.chan[0].st == QCT_ST_RUN && count_v[0] && tick_v[0] &&
    run_ok_v[0] && en_v[0] && !WR_EN && s.chan[0].cnt == 16'hFFFF
    |=> s.chan[0].cnt == 16'h0 && s.chan[0].carry)
    else $error("event counter did not wrap to zero");

  a_cascade_step: assert property (
    s.cascade[0] && s.chan[0].carry && s.chan[1].st == QCT_ST_RUN &&
    count_v[1] && run_ok_v[1] && en_v[1] && !WR_EN
    |=> s.chan[1].cnt == $past(s.chan[1].cnt) + 16'd1)
    else $error("cascaded upper counter missed lower carry");

  a_gate_low_pause: assert property (
    s.chan[1].gate == QCT_GATE_LOW && EXT_GATE[1] && count_v[1] &&
    !s.cascade[0] && !WR_EN |=> s.chan[1].cnt == $past(s.chan[1].cnt))
    else $error("low gate did not pause counting");

  a_shot_done: assert property (
    s_shot_end |=> s.chan[2].st == QCT_ST_DONE ##1
      (s.chan[2].st == QCT_ST_DONE || $past(WR_EN) || !$past(en_v[2])))
    else $error("one-shot did not stop after its pulse");

  a_idle_polarity: assert property (
    s_idle_two |-> PULSE_OUT[0] == $past(s.chan[0].pol_hl))
    else $error("idle pulse pin not at inactive level");

  a_divider_floor: assert property (
    div_v[2] >= DIV_MIN && act_v[2] <= div_v[2])
    else $error("divider below two or active length too long");

  a_edge_trigger: assert property (
    s.chan[2].st == QCT_ST_ARMED && s.chan[2].gate == QCT_GATE_RISE &&
    !s.cascade[1] && en_v[2] && !WR_EN && !EXT_GATE[2] ##1
    EXT_GATE[2] && !WR_EN ##1 !WR_EN |=> s.chan[2].st == QCT_ST_RUN)
    else $error("rising gate edge did not trigger");

  a_start_on_edge: assert property (
    s.chan[2].st == QCT_ST_ARMED && trig_v[2] && en_v[2] && !WR_EN
    |=> PULSE_OUT[2] == s.chan[2].pol_hl)
    else $error("pulse began before the first clock edge");

  a_rate_halt: assert property (
    s.chan[3].st == QCT_ST_RUN && s.chan[3].mode == QCT_MODE_RATE &&
    !run_ok_v[3] && !WR_EN |=> PULSE_OUT[3] == s.chan[3].pol_hl)
    else $error("rate output kept running with gate closed");

  a_repeat_rearm: assert property (
    s.chan[2].st == QCT_ST_RUN && s.chan[2].mode == QCT_MODE_REPEAT &&
    tick_v[2] && run_ok_v[2] && en_v[2] && !WR_EN &&
    s.chan[2].phase >= div_v[2] |=> s.chan[2].st == QCT_ST_ARMED)
    else $error("repetitive one-shot did not re-arm");

endmodule : qct_unit

`default_nettype wire

// ===== include/qct_pkg.sv
package qct_pkg;

  // channel count and counter width
  localparam int          NUM_CH        = 4;
  localparam int          CNT_W         = 16;

  // time base derivation: system clock and internal time base, in MHz
  localparam int          SYS_CLK_MHZ   = 100;
  localparam int          TIME_BASE_MHZ = 20;
  localparam logic [2:0]  TB_CYCLES     = 3'(SYS_CLK_MHZ / TIME_BASE_MHZ);

  // divider and duty limits
  localparam logic [15:0] DIV_MIN       = 16'h0002;
  localparam logic [6:0]  DUTY_FULL     = 7'h64;
  localparam logic [6:0]  DUTY_HALF     = 7'h32;

  // register map, byte addresses
  localparam logic [7:0]  CH_STRIDE     = 8'h10;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_DIV       = 4'h4;
  localparam logic [3:0]  REG_DUTY      = 4'h8;
  localparam logic [3:0]  REG_COUNT     = 4'hC;
  localparam logic [7:0]  REG_CASCADE   = 8'h40;
  localparam logic [7:0]  REG_ADC_DIV   = 8'h44;
  localparam logic [7:0]  REG_STATUS    = 8'h48;

  // control register field positions
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_GATE_LSB = 3;
  localparam int          CTRL_EXT_BIT  = 6;
  localparam int          CTRL_POL_BIT  = 7;
  localparam int          CTRL_EN_BIT   = 8;

  // reset values
  localparam logic [15:0] DIV_RST       = 16'h0002;
  localparam logic [15:0] ADC_DIV_RST   = 16'h0002;

  typedef enum logic [2:0] {
    QCT_MODE_EVENT  = 3'h0,
    QCT_MODE_FREQ   = 3'h1,
    QCT_MODE_RATE   = 3'h2,
    QCT_MODE_SHOT   = 3'h3,
    QCT_MODE_REPEAT = 3'h4
  } qct_mode_t;

  typedef enum logic [2:0] {
    QCT_GATE_NONE = 3'h0,
    QCT_GATE_LOW  = 3'h1,
    QCT_GATE_HIGH = 3'h2,
    QCT_GATE_FALL = 3'h3,
    QCT_GATE_RISE = 3'h4
  } qct_gate_t;

  // gray coded along idle, armed, run, done
  typedef enum logic [1:0] {
    QCT_ST_IDLE  = 2'b00,
    QCT_ST_ARMED = 2'b01,
    QCT_ST_RUN   = 2'b11,
    QCT_ST_DONE  = 2'b10
  } qct_state_t;

  typedef struct packed {
    qct_state_t  st;
    logic [15:0] cnt;
    logic [15:0] phase;
    logic        out;
    logic        carry;
    logic        clk_prev;
    logic        gate_prev;
    qct_mode_t   mode;
    qct_gate_t   gate;
    logic        ext;
    logic        pol_hl;
    logic        en;
    logic [15:0] div;
    logic [6:0]  duty;
  } qct_chan_t;

  typedef struct packed {
    qct_chan_t [3:0] chan;
    logic [2:0]      cascade;
    logic [2:0]      tb_cnt;
    logic            tb_tick;
    logic [15:0]     adc_div;
    logic [15:0]     adc_cnt;
    logic            adc_tick;
    logic [31:0]     rd_data;
  } qct_regs_t;

endpackage : qct_pkg

// ===== testbench/qct_ext_src.sv
`timescale 1ns/1ps
`default_nettype none

// far side model: external clock and gate sources for all four channels
module qct_ext_src (
  input  wire logic       clk,
  output var  logic [3:0] ext_clk,
  output var  logic [3:0] ext_gate
);
  // clocks stand low outside bursts, gates start low
  initial begin
    ext_clk  = 4'h0;
    ext_gate = 4'h0;
  end

  // burst of rising edges, two cycles high and two low, so each is seen
  // and the divided output stays far below the external limit
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      ext_clk[ch] <= 1'b1;
      repeat (2) @(posedge clk);
      ext_clk[ch] <= 1'b0;
    end
  endtask : pulses

  // gate level change launched just after an edge
  task automatic set_gate(input int ch, input logic v);
    @(posedge clk);
    ext_gate[ch] <= v;
  endtask : set_gate
endmodule : qct_ext_src

`default_nettype wire

// ===== testbench/qct_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module qct_unit_tb
  import qct_pkg::*;
;
  logic        CLOCK;
  logic        RESET_N;
  logic [7:0]  ADDR;
  logic [31:0] WR_DATA;
  logic        WR_EN;
  logic        RD_EN;
  logic [31:0] RD_DATA;
  wire  [3:0]  EXT_CLK;
  wire  [3:0]  EXT_GATE;
  logic [3:0]  PULSE_OUT;
  logic        ADC_TICK;
  int          miscompares;
  int          tests_run;
  logic [31:0] d;
  int          hi;

  qct_unit uut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .EXT_CLK(EXT_CLK), .EXT_GATE(EXT_GATE), .PULSE_OUT(PULSE_OUT),
    .ADC_TICK(ADC_TICK));

  qct_ext_src src (.clk(CLOCK), .ext_clk(EXT_CLK), .ext_gate(EXT_GATE));

  // 100 MHz clock
  initial CLOCK = 1'b0;
  always #5 CLOCK = ~CLOCK;

  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
    return 8'(ch) * CH_STRIDE + {4'h0, off};
  endfunction : ra

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR    <= a;
    WR_DATA <= v;
    WR_EN   <= 1'b1;
    @(posedge CLOCK);
    WR_EN   <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge CLOCK);
    RD_EN <= 1'b0;
    #1 v = RD_DATA;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rdchk

  // cycles spent at the active level; pol 1 means active low
  task automatic active(input int ch, input logic pol, input int n,
                        output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge CLOCK);
      #1 if ((PULSE_OUT[ch] ^ pol) === 1'b1) cnt++;
    end
  endtask : active

  // watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    miscompares = 0;
    tests_run   = 0;
    RESET_N     = 1'b0;
    ADDR        = 8'h00;
    WR_DATA     = 32'h0000_0000;
    WR_EN       = 1'b0;
    RD_EN       = 1'b0;
    repeat (10) @(posedge CLOCK);
    RESET_N <= 1'b1;
    // reset values, clamping, read-only and unmapped places
    rdchk(ra(0, REG_CTRL), 32'h0000_0000);
    rdchk(ra(3, REG_DIV), 32'h0000_0002);
    rdchk(ra(2, REG_DUTY), 32'h0000_0032);
    rdchk(REG_CASCADE, 32'h0000_0000);
    wr(ra(1, REG_DUTY), 32'h0000_007F);
    rdchk(ra(1, REG_DUTY), 32'h0000_0064);
    wr(ra(3, REG_COUNT), 32'h0000_1234);
    rdchk(ra(3, REG_COUNT), 32'h0000_0000);
    wr(8'h4C, 32'h0000_FFFF);
    rdchk(8'h4C, 32'h0000_0000);
    // event count, external clock, software gate
    wr(ra(0, REG_CTRL), 32'h0000_0140);
    src.pulses(0, 5);
    repeat (4) @(posedge CLOCK);
    rdchk(ra(0, REG_COUNT), 32'h0000_0005);
    // high level gate: only edges while gate is high count
    wr(ra(1, REG_CTRL), 32'h0000_0150);
    src.pulses(1, 3);
    src.set_gate(1, 1'b1);
    src.pulses(1, 4);
    src.set_gate(1, 1'b0);
    src.pulses(1, 2);
    rdchk(ra(1, REG_COUNT), 32'h0000_0004);
    // low level gate in frequency mode: counting pauses once gate is high
    wr(ra(1, REG_CTRL), 32'h0000_0149);
    src.pulses(1, 3);
    src.set_gate(1, 1'b1);
    src.pulses(1, 2);
    rdchk(ra(1, REG_COUNT), 32'h0000_0003);
    src.set_gate(1, 1'b0);
    // rate generation, internal base, div 4: period 20 cycles, 10 periods
    wr(ra(3, REG_DIV), 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      wr(ra(3, REG_DUTY), i == 0 ? 32'h32 : i == 1 ? 32'h4B : 32'h19);
      wr(ra(3, REG_CTRL), i == 2 ? 32'h0000_0182 : 32'h0000_0102);
      repeat (10) @(posedge CLOCK);
      active(3, i == 2, 200, hi);
      check(hi, i == 0 ? 100 : i == 1 ? 150 : 50);
    end
    // rate output stops while the high level gate is low
    wr(ra(3, REG_DUTY), 32'h0000_0032);
    wr(ra(3, REG_CTRL), 32'h0000_0112);
    active(3, 1'b0, 200, hi);
    check(hi, 0);
    src.set_gate(3, 1'b1);
    repeat (10) @(posedge CLOCK);
    active(3, 1'b0, 200, hi);
    check(hi, 100);
    // one shot on a rising gate: one pulse of 2 ticks, then done
    wr(ra(2, REG_DIV), 32'h0000_0004);
    wr(ra(2, REG_CTRL), 32'h0000_0123);
    rd(REG_STATUS, d);
    check((d >> 4) & 32'h3, 32'h1);
    src.set_gate(2, 1'b1);
    active(2, 1'b0, 100, hi);
    check(hi, 10);
    rd(REG_STATUS, d);
    check((d >> 4) & 32'h3, 32'h2);
    src.set_gate(2, 1'b0);
    src.set_gate(2, 1'b1);
    active(2, 1'b0, 100, hi);
    check(hi, 0);
    // falling edge trigger after a rewrite of the control word
    wr(ra(2, REG_CTRL), 32'h0000_011B);
    src.set_gate(2, 1'b0);
    active(2, 1'b0, 100, hi);
    check(hi, 10);
    // repetitive one shot: every rising gate edge gives one more pulse
    wr(ra(2, REG_CTRL), 32'h0000_0124);
    src.set_gate(2, 1'b1);
    active(2, 1'b0, 60, hi);
    check(hi, 10);
    src.set_gate(2, 1'b0);
    src.set_gate(2, 1'b1);
    active(2, 1'b0, 60, hi);
    check(hi, 10);
    // cascade 0-1: upper counts each 10-cycle period end of the lower
    wr(REG_CASCADE, 32'h0000_0001);
    wr(ra(1, REG_CTRL), 32'h0000_0100);
    wr(ra(0, REG_DIV), 32'h0000_0002);
    wr(ra(0, REG_CTRL), 32'h0000_0102);
    repeat (200) @(posedge CLOCK);
    rd(ra(1, REG_COUNT), d);
    check(32'(d >= 18 && d <= 22), 32'h1);
    // converter pacing tick every 4 base ticks, 20 cycles
    wr(REG_ADC_DIV, 32'h0000_0004);
    repeat (10) @(posedge CLOCK);
    hi = 0;
    repeat (200) begin
      @(posedge CLOCK);
      #1 if (ADC_TICK === 1'b1) hi++;
    end
    check(hi, 10);
    final_report();
  end
endmodule : qct_unit_tb

`default_nettype wire
